/* shared/sfs_pkg.sv */
// sfs_pkg: constants for the servo fault supervisor.
// assumes one drive clock; used by hw/sfs_*.sv.
package sfs_pkg;
  // ************
  // fault slots
  // ************
  localparam int NFAULT   = 18;
  localparam int F_OC     = 0;
  localparam int F_OV     = 1;
  localparam int F_UV     = 2;
  localparam int F_CSENS  = 3;
  localparam int F_ENC    = 4;
  localparam int F_NVM    = 5;
  localparam int F_PHASE  = 6;
  localparam int F_ICOMM  = 7;
  localparam int F_ISTEP  = 8;
  localparam int F_OT     = 9;
  localparam int F_OS     = 10;
  localparam int F_POSERR = 11;
  localparam int F_SOFTLM = 12;
  localparam int F_HOMECF = 13;
  localparam int F_DIDUP  = 14;
  localparam int F_NOHOME = 15;
  localparam int F_STO    = 16;
  localparam int F_STARTM = 17;
  // decimal fault numbers, one per slot
  localparam logic [15:0] CODE_TAB [NFAULT] = '{
    16'h0064, 16'h0066, 16'h0067, 16'h0068, 16'h0069, 16'h006A,
    16'h006B, 16'h006C, 16'h006D, 16'h0075, 16'h00CA, 16'h00CB,
    16'h00CF, 16'h00C8, 16'h00C9, 16'h00CD, 16'h0082, 16'h0083};
  // ************
  // register map
  // ************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_OC_THR  = 8'h08;
  localparam logic [7:0] ADDR_RATED_V = 8'h0C;
  localparam logic [7:0] ADDR_OT_THR  = 8'h10;
  localparam logic [7:0] ADDR_OS_THR  = 8'h14;
  localparam logic [7:0] ADDR_RATED_S = 8'h18;
  localparam logic [7:0] ADDR_PE_LIM  = 8'h1C;
  localparam logic [7:0] ADDR_SOFT_LO = 8'h20;
  localparam logic [7:0] ADDR_SOFT_HI = 8'h24;
  localparam logic [7:0] ADDR_PH_TOL  = 8'h28;
  localparam logic [7:0] ADDR_IC_TEST = 8'h2C;
  localparam logic [7:0] ADDR_IC_CHK  = 8'h30;
  localparam logic [7:0] ADDR_STATUS  = 8'h3C;
  localparam logic [7:0] ADDR_CODE    = 8'h40;
  localparam logic [7:0] ADDR_CLEAR   = 8'h44;
  localparam logic [7:0] ADDR_DI_FN   = 8'h80;
  // control fields and mask bit
  localparam int CTRL_CLASS380 = 0;
  localparam int CTRL_SOFTLIM  = 1;
  localparam int CTRL_REDWIRE  = 2;
  localparam int MASK_OC_BIT   = 1;
  localparam int CLEAR_BIT     = 0;
  // reset values
  localparam logic [15:0] RST_OC_THR  = 16'h012C;
  localparam logic [15:0] RST_RATED_V = 16'h00DC;
  localparam logic [15:0] RST_OT_THR  = 16'h0055;
  localparam logic [15:0] RST_OS_THR  = 16'h0078;
  localparam logic [15:0] RST_RATED_S = 16'h0BB8;
  // ************
  // limits
  // ************
  localparam logic [15:0] OV_220   = 16'h01A4;
  localparam logic [15:0] OV_380   = 16'h02EE;
  localparam int          UV_K1    = 1414;
  localparam int          UV_K2    = 700;
  localparam int          UV_SCALE = 1000;
  localparam logic [15:0] STEP_PCT = 16'h0032;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  localparam logic [7:0]  HOME_FN  = 8'h22;
  localparam logic [7:0]  STO_FN   = 8'h4B;
  // power-on current check states
  typedef enum logic [1:0] {
    SFS_PON_CHECK = 2'b01,
    SFS_PON_DONE  = 2'b10
  } sfs_pon_t;
endpackage : sfs_pkg

/* hw/sfs_fault_latch.sv */
// sfs_fault_latch: sticky fault bits and first fault code.
// assumes events are one-cycle or level, clear from regs.
`timescale 1ns/10ps
`default_nettype none
module sfs_fault_latch
  import sfs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [NFAULT-1:0] fault_ev,
  input  wire logic              clear,
  output logic      [NFAULT-1:0] status_q,
  output logic                   any_q,
  output logic      [15:0]       code_q
);
  logic [15:0] pick;     // code of lowest new event
  logic        hit;      // any new event this cycle
  // ************
  // priority pick
  // ************
  always_comb begin
    pick = 16'h0000;
    hit  = |fault_ev;
    for (int i = NFAULT - 1; i >= 0; i--) begin
      if (fault_ev[i]) begin
        pick = CODE_TAB[i];
      end
    end
  end
  // sticky bits, set beats clear
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= '0;
    end else if (clear) begin
      status_q <= fault_ev;
    end else begin
      status_q <= status_q | fault_ev;
    end
  end
  // first code held until clear
  always_ff @(posedge clk) begin
    if (srst) begin
      any_q  <= 1'b0;
      code_q <= 16'h0000;
    end else if (clear || !any_q) begin
      any_q  <= hit;
      code_q <= pick;
    end
  end
endmodule : sfs_fault_latch
`default_nettype wire

/* hw/sfs_supervisor.sv */
// sfs_supervisor: servo fault supervisor top with registers.
// assumes measurements synchronous to clk, one drive clock.
`timescale 1ns/10ps
`default_nettype none
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int NUM_DI = 8,  // digital inputs
  parameter int PH_W   = 12  // phase width
)
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [31:0]       rd_data,
  input  wire logic [15:0]       current_percent_meas,
  input  wire logic              current_sample_valid,
  input  wire logic              relay_closed,
  input  wire logic [15:0]       bus_voltage_meas,
  input  wire logic [15:0]       drive_temperature_meas,
  input  wire logic [15:0]       speed_actual,
  input  wire logic [31:0]       position_error_meas,
  input  wire logic [31:0]       encoder_position,
  input  wire logic              encoder_fail,
  input  wire logic              encoder_connected,
  input  wire logic [PH_W-1:0]   hall_phase,
  input  wire logic [PH_W-1:0]   encoder_phase,
  input  wire logic              phase_valid,
  input  wire logic              nvm_verify_valid,
  input  wire logic [31:0]       nvm_wr_value,
  input  wire logic [31:0]       nvm_rd_value,
  input  wire logic [NUM_DI-1:0] di_level,
  input  wire logic              home_start,
  input  wire logic              home_done,
  input  wire logic              abs_move_cmd,
  input  wire logic              motion_startup,
  output logic                   fault_active,
  output logic      [15:0]       fault_code,
  output logic      [NFAULT-1:0] fault_status
);
  localparam int NDIREG = (NUM_DI + 3) / 4; // slot words

  // ************
  // registers
  // ************
  logic [2:0]  ctrl_q;           // class, soft limit, wire
  logic [15:0] fault_mask_bits;  // suppress bits
  logic [15:0] overcurrent_threshold;
  logic [15:0] rated_voltage_setting;
  logic [15:0] overheat_threshold;
  logic [15:0] overspeed_threshold;
  logic [15:0] rated_speed_q;    // speed for 100 percent
  logic [31:0] position_error_limit;
  logic [31:0] soft_lo_q;        // signed lower bound
  logic [31:0] soft_hi_q;        // signed upper bound
  logic [PH_W-1:0] phase_tol_q;  // allowed phase gap
  logic [31:0] icomm_test_q;     // processor test word
  logic [NUM_DI*8-1:0] slots_q;  // input_function_slot
  logic        soft_limit_enable;
  logic        wr_clear;         // clear strobe
  logic [31:0] rd_d;             // read mux
  logic [NFAULT-1:0] fault_ev;   // this cycle events

  // ************
  // helpers
  // ************
  // inputs carrying a given function
  function automatic logic [NUM_DI-1:0] func_match(
    input logic [NUM_DI*8-1:0] slots,
    input logic [7:0]          fn
  );
    logic [NUM_DI-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_DI; i++) begin
      m[i] = (slots[i*8 +: 8] == fn);
    end
    return m;
  endfunction : func_match

  // write hit on one address
  function automatic logic wr_hit(
    input logic       we,
    input logic [7:0] a,
    input logic [7:0] ref_a
  );
    return we && (a == ref_a);
  endfunction : wr_hit

  assign soft_limit_enable = ctrl_q[CTRL_SOFTLIM];
  assign wr_clear = wr_hit(wr_en, addr, ADDR_CLEAR) && wr_data[CLEAR_BIT];

  // config register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q                <= 3'h0;
      fault_mask_bits       <= 16'h0000;
      overcurrent_threshold <= RST_OC_THR;
      rated_voltage_setting <= RST_RATED_V;
      overheat_threshold    <= RST_OT_THR;
      overspeed_threshold   <= RST_OS_THR;
      rated_speed_q         <= RST_RATED_S;
      position_error_limit  <= 32'h0000_0000;
      soft_lo_q             <= 32'h0000_0000;
      soft_hi_q             <= 32'h0000_0000;
      phase_tol_q           <= '0;
      icomm_test_q          <= 32'h0000_0000;
    end else if (wr_en) begin
      case (addr)
        ADDR_CTRL:    ctrl_q                <= wr_data[2:0];
        ADDR_MASK:    fault_mask_bits       <= wr_data[15:0];
        ADDR_OC_THR:  overcurrent_threshold <= wr_data[15:0];
        ADDR_RATED_V: rated_voltage_setting <= wr_data[15:0];
        ADDR_OT_THR:  overheat_threshold    <= wr_data[15:0];
        ADDR_OS_THR:  overspeed_threshold   <= wr_data[15:0];
        ADDR_RATED_S: rated_speed_q         <= wr_data[15:0];
        ADDR_PE_LIM:  position_error_limit  <= wr_data;
        ADDR_SOFT_LO: soft_lo_q             <= wr_data;
        ADDR_SOFT_HI: soft_hi_q             <= wr_data;
        ADDR_PH_TOL:  phase_tol_q           <= wr_data[PH_W-1:0];
        ADDR_IC_TEST: icomm_test_q          <= wr_data;
        default: ;                          // others elsewhere
      endcase
    end
  end

  // input function slots, four per word
  generate
    for (genvar g = 0; g < NUM_DI; g++) begin : g_slot
      localparam logic [7:0] SLOT_A = ADDR_DI_FN + 8'((g / 4) * 4);
      always_ff @(posedge clk) begin
        if (srst) begin
          slots_q[g*8 +: 8] <= 8'h00;
        end else if (wr_hit(wr_en, addr, SLOT_A)) begin
          slots_q[g*8 +: 8] <= wr_data[(g % 4)*8 +: 8];
        end
      end
    end
  endgenerate

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    case (addr)
      ADDR_CTRL:    rd_d = {29'h0, ctrl_q};
      ADDR_MASK:    rd_d = {16'h0, fault_mask_bits};
      ADDR_OC_THR:  rd_d = {16'h0, overcurrent_threshold};
      ADDR_RATED_V: rd_d = {16'h0, rated_voltage_setting};
      ADDR_OT_THR:  rd_d = {16'h0, overheat_threshold};
      ADDR_OS_THR:  rd_d = {16'h0, overspeed_threshold};
      ADDR_RATED_S: rd_d = {16'h0, rated_speed_q};
      ADDR_PE_LIM:  rd_d = position_error_limit;
      ADDR_SOFT_LO: rd_d = soft_lo_q;
      ADDR_SOFT_HI: rd_d = soft_hi_q;
      ADDR_PH_TOL:  rd_d = 32'(phase_tol_q);
      ADDR_IC_TEST: rd_d = icomm_test_q;
      ADDR_STATUS:  rd_d = 32'(fault_status);
      ADDR_CODE:    rd_d = {15'h0, fault_active, fault_code};
      default: begin
        // slot words, unmapped reads zero
        for (int w = 0; w < NDIREG; w++) begin
          if (addr == ADDR_DI_FN + 8'(w * 4)) begin
            for (int b = 0; b < 4; b++) begin
              if (w * 4 + b < NUM_DI) begin
                rd_d[b*8 +: 8] = slots_q[(w*4+b)*8 +: 8];
              end
            end
          end
        end
      end
    endcase
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      rd_data <= rd_d;
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // ************
  // sequence state
  // ************
  sfs_pon_t    pon_q;       // power-on check state
  logic        homed_q;     // a return to home finished
  logic [15:0] prev_cur_q;  // last current sample
  logic        prev_ok_q;   // prev_cur_q holds a sample

  // power-on current check until relay closes
  always_ff @(posedge clk) begin
    if (srst) begin
      pon_q <= SFS_PON_CHECK;
    end else begin
      case (pon_q)
        SFS_PON_CHECK: begin
          if (relay_closed) begin
            pon_q <= SFS_PON_DONE;
          end
        end
        SFS_PON_DONE: pon_q <= SFS_PON_DONE;
        default:      pon_q <= SFS_PON_CHECK;
      endcase
    end
  end

  // homing done memory
  always_ff @(posedge clk) begin
    if (srst) begin
      homed_q <= 1'b0;
    end else if (home_done) begin
      homed_q <= 1'b1;
    end
  end

  // previous current sample
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_cur_q <= 16'h0000;
      prev_ok_q  <= 1'b0;
    end else if (current_sample_valid) begin
      prev_cur_q <= current_percent_meas;
      prev_ok_q  <= 1'b1;
    end
  end

  // ************
  // detection
  // ************
  logic [47:0] uv_lhs;           // scaled bus voltage
  logic [47:0] uv_rhs;           // scaled rated * factors
  logic [31:0] spd_pct_x;        // speed * 100
  logic [31:0] spd_lim_x;        // threshold * rated
  logic [15:0] cur_diff;         // sample step size
  logic [PH_W-1:0] ph_diff;      // wrapped phase gap
  logic [NUM_DI-1:0] home_hits;  // inputs with home fn
  logic [NUM_DI-1:0] sto_hits;   // inputs with alarm fn
  logic        dup_fn;           // duplicated function

  assign uv_lhs = 48'(bus_voltage_meas) * 48'(UV_SCALE * UV_SCALE);
  assign uv_rhs = 48'(rated_voltage_setting) * 48'(UV_K1 * UV_K2);
  assign spd_pct_x = 32'(speed_actual) * 32'(PCT_FULL);
  assign spd_lim_x = 32'(overspeed_threshold) * 32'(rated_speed_q);
  assign home_hits = func_match(slots_q, HOME_FN);
  assign sto_hits  = func_match(slots_q, STO_FN);

  // absolute step and phase gap
  always_comb begin
    cur_diff = (current_percent_meas >= prev_cur_q)
             ? (current_percent_meas - prev_cur_q)
             : (prev_cur_q - current_percent_meas);
    ph_diff = hall_phase - encoder_phase;
    if (ph_diff[PH_W-1]) begin
      ph_diff = PH_W'(0) - ph_diff; // shortest way round
    end
  end

  // duplicated nonzero function across inputs
  always_comb begin
    dup_fn = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      for (int j = i + 1; j < NUM_DI; j++) begin
        if (slots_q[i*8 +: 8] != 8'h00 &&
            slots_q[i*8 +: 8] == slots_q[j*8 +: 8]) begin
          dup_fn = 1'b1;
        end
      end
    end
  end

  // per-fault events this cycle
  always_comb begin
    fault_ev = '0;
    fault_ev[F_OC] = (current_percent_meas > overcurrent_threshold)
                   && !fault_mask_bits[MASK_OC_BIT];
    fault_ev[F_OV] = ctrl_q[CTRL_CLASS380]
                   ? (bus_voltage_meas > OV_380)
                   : (bus_voltage_meas > OV_220);
    fault_ev[F_UV] = (uv_lhs < uv_rhs);
    fault_ev[F_CSENS] = (pon_q == SFS_PON_CHECK) && !relay_closed
                      && current_sample_valid
                      && (current_percent_meas != 16'h0000);
    fault_ev[F_ENC] = encoder_fail || !encoder_connected;
    fault_ev[F_NVM] = nvm_verify_valid
                    && (nvm_wr_value != nvm_rd_value);
    fault_ev[F_PHASE] = phase_valid && (ph_diff > phase_tol_q);
    fault_ev[F_ICOMM] = wr_hit(wr_en, addr, ADDR_IC_CHK)
                      && (wr_data != icomm_test_q);
    fault_ev[F_ISTEP] = current_sample_valid && prev_ok_q
                      && (cur_diff >= STEP_PCT);
    fault_ev[F_OT] = drive_temperature_meas > overheat_threshold;
    fault_ev[F_OS] = spd_pct_x > spd_lim_x;
    fault_ev[F_POSERR] = (position_error_limit != 32'h0000_0000)
                       && (position_error_meas > position_error_limit);
    fault_ev[F_SOFTLM] = soft_limit_enable
                       && (($signed(encoder_position) < $signed(soft_lo_q))
                       || ($signed(encoder_position) > $signed(soft_hi_q)));
    fault_ev[F_HOMECF] = home_start && !(|home_hits);
    fault_ev[F_DIDUP]  = dup_fn;
    fault_ev[F_NOHOME] = abs_move_cmd && !homed_q;
    fault_ev[F_STO]    = |(sto_hits & di_level);
    fault_ev[F_STARTM] = ctrl_q[CTRL_REDWIRE] && motion_startup
                       && (speed_actual != 16'h0000);
  end

  // ************
  // fault latch
  // ************
  sfs_fault_latch u_latch (
    .clk      (clk),
    .srst     (srst),
    .fault_ev (fault_ev),
    .clear    (wr_clear),
    .status_q (fault_status),
    .any_q    (fault_active),
    .code_q   (fault_code)
  );
endmodule : sfs_supervisor
`default_nettype wire

/* testbench/sfs_supervisor_properties.sv */
// sfs_supervisor_properties: port assertions for the fault supervisor.
// assumes bind onto sfs_supervisor, one clock, sync active-high reset.
`timescale 1ns/10ps
`default_nettype none
module sfs_supervisor_properties
  import sfs_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [31:0]       rd_data,
  input wire logic [15:0]       bus_voltage_meas,
  input wire logic              encoder_fail,
  input wire logic              encoder_connected,
  input wire logic              fault_active,
  input wire logic [15:0]       fault_code,
  input wire logic [NFAULT-1:0] fault_status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // clear command on the bus
  wire logic clr = wr_en && addr == ADDR_CLEAR && wr_data[CLEAR_BIT];
  // ************
  // sequences
  // ************
  sequence s_read(a);
    rd_en && addr == a;
  endsequence
  sequence s_clear_quiet;
    clr && bus_voltage_meas <= OV_220 && encoder_connected && !encoder_fail;
  endsequence
  // ************
  // assertions
  // ************
  a_read_idle_zero: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  a_status_read: assert property (s_read(ADDR_STATUS) |=> rd_data == {14'h0, $past(fault_status)})
    else $error("status read wrong");
  a_code_read: assert property
    (s_read(ADDR_CODE) |=> rd_data == {15'h0, $past(fault_active), $past(fault_code)})
    else $error("code read wrong");
  a_ov_high: assert property
    (bus_voltage_meas > OV_380 |=> fault_status[F_OV] && fault_active)
    else $error("overvoltage not latched");
  a_enc_lost: assert property ((encoder_fail || !encoder_connected) |=> fault_status[F_ENC])
    else $error("encoder fault not latched");
  a_fault_sticky: assert property (fault_active && !clr |=>
    ((fault_status & $past(fault_status)) == $past(fault_status)) && $stable(fault_code))
    else $error("latched fault lost");
  a_active_match: assert property (fault_active == (fault_status != '0))
    else $error("active flag disagrees with status");
  a_idle_code: assert property (!fault_active |-> fault_code == 16'h0000)
    else $error("code without fault");
  a_first_code: assert property
    ($rose(fault_active) && fault_status == NFAULT'(1 << F_OV) |-> fault_code == 16'h0066)
    else $error("first code wrong");
  a_clear_drops: assert property
    (s_clear_quiet |=> !fault_status[F_OV] && !fault_status[F_ENC])
    else $error("clear left stale bits");
endmodule : sfs_supervisor_properties
bind sfs_supervisor sfs_supervisor_properties i_sfs_supervisor_properties (
  .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .bus_voltage_meas(bus_voltage_meas), .encoder_fail(encoder_fail),
  .encoder_connected(encoder_connected), .fault_active(fault_active),
  .fault_code(fault_code), .fault_status(fault_status));
`default_nettype wire

/* testbench/sfs_drive_model.sv */
// sfs_drive_model: measurement path of a healthy drive, upset on command.
// assumes drive() is called just after a rising clk edge.
`timescale 1ns/10ps
`default_nettype none
module sfs_drive_model
  import sfs_pkg::*;
#(
  parameter int NUM_DI = 8,
  parameter int PH_W   = 12
)
(
  input  wire logic        clk,
  output logic [15:0]       current_percent_meas,
  output logic              current_sample_valid,
  output logic              relay_closed,
  output logic [15:0]       bus_voltage_meas,
  output logic [15:0]       drive_temperature_meas,
  output logic [15:0]       speed_actual,
  output logic [31:0]       position_error_meas,
  output logic [31:0]       encoder_position,
  output logic              encoder_fail,
  output logic              encoder_connected,
  output logic [PH_W-1:0]   hall_phase,
  output logic [PH_W-1:0]   encoder_phase,
  output logic              phase_valid,
  output logic              nvm_verify_valid,
  output logic [31:0]       nvm_wr_value,
  output logic [31:0]       nvm_rd_value,
  output logic [NUM_DI-1:0] di_level,
  output logic              home_start,
  output logic              home_done,
  output logic              abs_move_cmd,
  output logic              motion_startup
);
  // healthy power-up: relay open, bus mid band, encoder present
  initial begin
    {current_percent_meas, current_sample_valid, relay_closed} = '0;
    bus_voltage_meas = 16'h0136;
    drive_temperature_meas = 16'h0019;
    {speed_actual, position_error_meas, encoder_position, encoder_fail} = '0;
    encoder_connected = 1'b1;
    {hall_phase, encoder_phase, nvm_verify_valid} = '0;
    phase_valid = 1'b1;
    nvm_wr_value = 32'h0000_1234;
    nvm_rd_value = 32'h0000_1234;
    {di_level, home_start, home_done, abs_move_cmd, motion_startup} = '0;
  end
  // one-cycle strobes drop by themselves
  always @(posedge clk) begin
    if (current_sample_valid) current_sample_valid <= 1'b0;
    if (nvm_verify_valid) nvm_verify_valid <= 1'b0;
    if (home_start) home_start <= 1'b0;
    if (abs_move_cmd) abs_move_cmd <= 1'b0;
  end
  // upset (on=1) or heal (on=0) one monitored quantity
  task automatic drive(input int k, input logic on);
    case (k)
      F_OC: current_percent_meas <= on ? 16'h012D : 16'h0000;
      F_OV: bus_voltage_meas <= on ? 16'h01A5 : 16'h0136;
      F_UV: bus_voltage_meas <= on ? 16'h0064 : 16'h0136;
      F_CSENS: current_percent_meas <= on ? 16'h0005 : 16'h0000;
      F_ENC: encoder_connected <= !on;
      F_NVM: begin
        nvm_verify_valid <= on;
        nvm_rd_value <= on ? 32'h0000_1235 : 32'h0000_1234;
      end
      F_PHASE: encoder_phase <= on ? {1'b1, {(PH_W-1){1'b0}}} : '0;
      F_ISTEP: current_percent_meas <= on ? 16'h003C : 16'h0000;
      F_OT: drive_temperature_meas <= on ? 16'h0056 : 16'h0019;
      F_OS: speed_actual <= on ? 16'h0E11 : 16'h0000;
      F_POSERR: position_error_meas <= on ? 32'h0000_03E9 : 32'h0;
      F_SOFTLM: encoder_position <= on ? 32'h0000_0065 : 32'h0;
      F_HOMECF: home_start <= on;
      F_NOHOME: abs_move_cmd <= on;
      F_STO: di_level[0] <= on;
      F_STARTM: begin
        motion_startup <= on;
        speed_actual <= {15'h0, on};
      end
      default: ;
    endcase
    // a fresh current sample; healing the sensor check closes the relay
    if (k == F_OC || k == F_ISTEP || k == F_CSENS) current_sample_valid <= 1'b1;
    if (k == F_CSENS && !on) relay_closed <= 1'b1;
  endtask : drive
endmodule : sfs_drive_model
`default_nettype wire

/* testbench/sfs_supervisor_tb_top.sv */
// sfs_supervisor_tb_top: register-driven test of the fault supervisor.
// assumes the drive model on the measurement side and the checker bound in.
`timescale 1ns/10ps
`default_nettype none
module sfs_supervisor_tb_top;
  import sfs_pkg::*;
  logic [15:0]       current_percent_meas, bus_voltage_meas, drive_temperature_meas;
  logic [15:0]       speed_actual, fault_code;
  logic [31:0]       position_error_meas, encoder_position, nvm_wr_value, nvm_rd_value;
  logic [31:0]       wr_data, rd_data;
  logic [11:0]       hall_phase, encoder_phase;
  logic [7:0]        di_level, addr;
  logic [NFAULT-1:0] fault_status, st;
  logic              clk, srst, wr_en, rd_en, current_sample_valid, relay_closed;
  logic              encoder_fail, encoder_connected, phase_valid, nvm_verify_valid;
  logic              home_start, home_done, abs_move_cmd, motion_startup, fault_active;
  int                bad_count = 0, compares = 0, cycles = 0, k;
  // decimal fault numbers per slot
  localparam logic [15:0] exp_code [NFAULT] = '{
    16'h0064, 16'h0066, 16'h0067, 16'h0068, 16'h0069, 16'h006A, 16'h006B, 16'h006C,
    16'h006D, 16'h0075, 16'h00CA, 16'h00CB, 16'h00CF, 16'h00C8, 16'h00C9, 16'h00CD,
    16'h0082, 16'h0083};
  sfs_supervisor  i_sfs_supervisor (.*);
  sfs_drive_model i_sfs_drive_model (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk32(rd_data, exp);
  endtask : rd_chk
  // bus-side faults come from us, the rest from the drive model
  task automatic poke(input int f, input logic on);
    if (f == F_ICOMM && on) begin
      wr(ADDR_IC_CHK, 32'h0000_005B);
    end else if (f == F_DIDUP) begin
      wr(ADDR_DI_FN, on ? 32'h0505_004B : 32'h0000_004B);
    end else begin
      i_sfs_drive_model.drive(f, on);
    end
  endtask : poke
  // upset, read status and code, heal, clear, expect all quiet
  task automatic run_case(input int f, input logic [NFAULT-1:0] s, input logic [15:0] c);
    poke(f, 1'b1);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, {14'h0, s});
    rd_chk(ADDR_CODE, {15'h0, |s, c});
    chk32({15'h0, fault_active, fault_code}, {15'h0, |s, c});
    chk32(32'(fault_status), {14'h0, s});
    poke(f, 1'b0);
    repeat (2) @(posedge clk);
    wr(ADDR_CLEAR, 32'h1);
    rd_chk(ADDR_STATUS, 32'h0);
  endtask : run_case
  initial begin
    srst = 1'b1;
    {wr_en, rd_en, addr, wr_data} = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_chk(ADDR_OC_THR, 32'h0000_012C);
    rd_chk(ADDR_RATED_V, 32'h0000_00DC);
    rd_chk(ADDR_OT_THR, 32'h0000_0055);
    rd_chk(ADDR_OS_THR, 32'h0000_0078);
    rd_chk(ADDR_RATED_S, 32'h0000_0BB8);
    rd_chk(8'h34, 32'h0);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd_chk(ADDR_STATUS, 32'h0);
    // soft limit and reduced-wire encoder on, limits set
    wr(ADDR_CTRL, 32'h6);
    wr(ADDR_PE_LIM, 32'h0000_03E8);
    wr(ADDR_SOFT_LO, 32'hFFFF_FF9C);
    wr(ADDR_SOFT_HI, 32'h0000_0064);
    wr(ADDR_PH_TOL, 32'h0000_0064);
    wr(ADDR_IC_TEST, 32'h0000_005A);
    rd_chk(ADDR_IC_TEST, 32'h0000_005A);
    wr(ADDR_IC_CHK, 32'h0000_005A);
    wr(ADDR_DI_FN, 32'h0000_004B);
    rd_chk(ADDR_STATUS, 32'h0);
    // sensor check first, while the relay is still open
    for (int i = 0; i < NFAULT; i++) begin
      k = (i + F_CSENS) % NFAULT;
      st = NFAULT'(1) << k;
      if (k == F_OC) st[F_ISTEP] = 1'b1;
      run_case(k, st, exp_code[k]);
    end
    // a later lower-index fault must not replace the first code
    poke(F_OT, 1'b1);
    repeat (2) @(posedge clk);
    poke(F_ENC, 1'b1);
    rd_chk(ADDR_CODE, 32'h0001_0075);
    rd_chk(ADDR_STATUS, 32'h0000_0210);
    poke(F_OT, 1'b0);
    poke(F_ENC, 1'b0);
    wr(ADDR_CLEAR, 32'h1);
    wr(ADDR_MASK, 32'h2);
    run_case(F_OC, 18'h00100, 16'h006D);
    wr(ADDR_PE_LIM, 32'h0);
    run_case(F_POSERR, '0, 16'h0);
    wr(ADDR_CTRL, 32'h7);
    run_case(F_OV, '0, 16'h0);
    i_sfs_drive_model.bus_voltage_meas <= 16'h02EF;
    i_sfs_drive_model.encoder_position <= 32'hFFFF_FF9B;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, 32'h0000_1002);
    poke(F_OV, 1'b0);
    poke(F_SOFTLM, 1'b0);
    wr(ADDR_CLEAR, 32'h1);
    rd_chk(ADDR_STATUS, 32'h0);
    // home input assigned and homing done: no homing faults
    i_sfs_drive_model.home_done <= 1'b1;
    wr(ADDR_DI_FN, 32'h0000_224B);
    poke(F_HOMECF, 1'b1);
    poke(F_NOHOME, 1'b1);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, 32'h0);
    complete_run();
  end
endmodule : sfs_supervisor_tb_top
`default_nettype wire
